//--- rtl/aso_defs.svh
`ifndef ASO_DEFS_SVH
`define ASO_DEFS_SVH

// ==========================================================================
// Register map
`define ASO_CTRL_OFS 4'h0
`define ASO_STAT_OFS 4'h4
`define ASO_CTRL_DLLOFF_BIT 0
`define ASO_CTRL_SLEEP_BIT 1
`define ASO_STAT_LOST_BIT 0
`define ASO_STAT_DLLON_BIT 1
`define ASO_STAT_RST_BIT 2
`define ASO_CTRL_DLLOFF_RST 1'b0
`define ASO_CTRL_SLEEP_RST 1'b0

// ==========================================================================
// Format select pin fields
`define ASO_FMT_TWOS_BIT 0
`define ASO_FMT_FALL_BIT 1

// ==========================================================================
// Output codes
`define ASO_POS_FULL_SOB 14'h3FFF
`define ASO_POS_FULL_TC 14'h1FFF
`define ASO_NEG_FULL_SOB 14'h0000
`define ASO_NEG_FULL_TC 14'h2000
`define ASO_TC_FLIP 14'h2000

// ==========================================================================
// Timing
`define ASO_CLK_MHZ 125
`define ASO_RST_MIN_US 2
`define ASO_RST_MIN_CYC (`ASO_RST_MIN_US * `ASO_CLK_MHZ)
`define ASO_SLOW_MHZ 2
`define ASO_SLOW_CYC (`ASO_CLK_MHZ / `ASO_SLOW_MHZ)

`endif

//--- rtl/aso_pkg.sv
`include "aso_defs.svh"

package aso_pkg;

    // ======================================================================
    // Types
    typedef enum logic [0:0] {BUS_IDLE, BUS_ANSWER} aso_bus_type;

    typedef struct packed {
        aso_bus_type busSt;
        logic waitReq;
        logic [31:0] rdata;
        logic dllOff;
        logic sleep;
        logic [15:0] rstCnt;
        logic rstHold;
        logic liveSeen;
        logic [15:0] idleCnt;
        logic clockLost;
        logic powerDown;
    } aso_main_state_type;

    typedef struct packed {
        logic phase;
        logic ready;
        logic [13:0] result;
        logic rangeFlag;
        logic oe;
    } aso_link_state_type;

    // ======================================================================
    // Functions
    function automatic logic [13:0] aso_encode(input logic [13:0] code, input logic posOver,
                                               input logic negOver, input logic twos);
        if (posOver) begin
            return twos ? `ASO_POS_FULL_TC : `ASO_POS_FULL_SOB;
        end
        if (negOver) begin
            return twos ? `ASO_NEG_FULL_TC : `ASO_NEG_FULL_SOB;
        end
        return twos ? (code ^ `ASO_TC_FLIP) : code;
    endfunction

    function automatic logic aso_is_limit(input logic [13:0] v, input logic twos);
        if (twos) begin
            return (v == `ASO_POS_FULL_TC) || (v == `ASO_NEG_FULL_TC);
        end
        return (v == `ASO_POS_FULL_SOB) || (v == `ASO_NEG_FULL_SOB);
    endfunction

endpackage

//--- rtl/aso_ctrl_if.sv
`timescale 1ns/100ps

// ==========================================================================
// Levels between the register side and the sample clock side.
interface aso_ctrl_if;
    logic powerDown;
    logic resetHold;
    logic sysRst;
    logic liveToggle;

    modport main (output powerDown, output resetHold, output sysRst, input liveToggle);
    modport link (input powerDown, input resetHold, input sysRst, output liveToggle);
endinterface

//--- rtl/aso_sync.sv
`timescale 1ns/100ps

// ==========================================================================
// Two flip-flop level synchroniser.
module aso_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } aso_sync_type;

    aso_sync_type s_q;
    aso_sync_type s_d;

    always_comb begin
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;
endmodule // aso_sync

//--- rtl/aso_sample_path.sv
`timescale 1ns/100ps
`include "aso_defs.svh"

// ==========================================================================
// Sample clock side: format, over-range, ready clock and output enable.
module aso_sample_path import aso_pkg::*; (
    input wire logic sampleClockPos,
    aso_ctrl_if.link ctrl,
    input wire logic [13:0] coreCode,
    input wire logic corePosOver,
    input wire logic coreNegOver,
    input wire logic [1:0] formatPolaritySelect,
    input wire logic outputEnable,
    output logic [13:0] resultBits,
    output logic resultOe,
    output logic overRangeFlag,
    output logic sampleReadyClock
);
    aso_link_state_type s_q;
    aso_link_state_type s_d;
    logic linkRst;
    logic [4:0] ctlSync;
    logic holdSync;
    logic pdSync;
    logic oeSync;
    logic twos;
    logic fallMode;
    logic update;

    aso_sync #(.W(1)) u_rst_sync (
        .clk(sampleClockPos),
        .rst(1'b0),
        .d(ctrl.sysRst),
        .q(linkRst)
    );

    aso_sync #(.W(5)) u_ctl_sync (
        .clk(sampleClockPos),
        .rst(linkRst),
        .d({ctrl.resetHold, ctrl.powerDown, outputEnable, formatPolaritySelect}),
        .q(ctlSync)
    );

    assign holdSync = ctlSync[4];
    assign pdSync = ctlSync[3];
    assign oeSync = ctlSync[2];
    assign twos = ctlSync[`ASO_FMT_TWOS_BIT];
    assign fallMode = ctlSync[`ASO_FMT_FALL_BIT];
    assign update = !holdSync && !pdSync && !s_q.phase;

    // Every sample spans two sample clock edges so the ready clock can place its latching edge mid-word.
    always_comb begin
        s_d = s_q;
        s_d.phase = !s_q.phase;
        s_d.oe = oeSync && !pdSync;
        if (holdSync) begin
            s_d.result = 14'h0000;
            s_d.rangeFlag = 1'b0;
            s_d.ready = 1'b0;
        end else if (pdSync) begin
            s_d.ready = 1'b0;
        end else if (update) begin
            s_d.result = aso_encode(coreCode, corePosOver, coreNegOver, twos);
            s_d.rangeFlag = aso_is_limit(s_d.result, twos);
            s_d.ready = fallMode;
        end else begin
            s_d.ready = !fallMode;
        end
    end

    always_ff @(posedge sampleClockPos) begin
        if (linkRst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign resultBits = s_q.result;
    assign resultOe = s_q.oe;
    assign overRangeFlag = s_q.rangeFlag;
    assign sampleReadyClock = s_q.ready;
    assign ctrl.liveToggle = s_q.phase;

    // ======================================================================
    // Checks
    default clocking cb @(posedge sampleClockPos); endclocking
    default disable iff (linkRst);

    posFull_code_a: assert property (update && corePosOver |=> resultBits == ($past(twos) ? 14'h1FFF : 14'h3FFF))
        else $error("positive overdrive code wrong");
    negFull_code_a: assert property (update && !corePosOver && coreNegOver
                                     |=> resultBits == ($past(twos) ? 14'h2000 : 14'h0000))
        else $error("negative overdrive code wrong");
    twos_code_a: assert property (update && twos && !corePosOver && !coreNegOver
                                  |=> resultBits == ($past(coreCode) ^ 14'h2000))
        else $error("two's complement code wrong");
    range_limit_a: assert property (overRangeFlag |-> resultBits inside {14'h3FFF, 14'h1FFF, 14'h0000, 14'h2000})
        else $error("over-range flag without limit code");
    oe_off_a: assert property (!oeSync |=> !resultOe)
        else $error("outputs driven while disabled");
    sleep_hiz_a: assert property (pdSync |=> !resultOe ##1 !resultOe or !pdSync)
        else $error("outputs driven in power-down");
    ready_edge_a: assert property (update && !fallMode ##1 (!holdSync && !pdSync && !fallMode)
                                   |-> !sampleReadyClock ##1 sampleReadyClock)
        else $error("ready clock rising edge missing");
    fall_edge_a: assert property (update && fallMode ##1 (!holdSync && !pdSync && fallMode)
                                  |-> sampleReadyClock ##1 !sampleReadyClock)
        else $error("ready clock falling edge missing");
    same_sample_a: assert property (($changed(resultBits) || $changed(overRangeFlag))
                                    |-> !$past(s_q.phase) || $past(holdSync))
        else $error("data and flag changed off the update edge");
    reset_low_a: assert property (holdSync |=> resultBits == 14'h0000 && !overRangeFlag)
        else $error("data not low during reset hold");

    posOver_c: cover property (update && corePosOver);
    fallMode_c: cover property (update && fallMode ##1 !sampleReadyClock);
endmodule // aso_sample_path

//--- rtl/aso_sample_port.sv
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`include "aso_defs.svh"

// ==========================================================================
// Function
// - Fourteen result bits, bit thirteen most significant.
// - Ready clock accompanies every result word.
// - Over-range flag high at full-scale codes.
// - Offset binary or two's complement per select.
// - Select pins choose latching edge too.
// - Output enable low puts data high-impedance.
// - Positive overdrive gives 3FFF or 1FFF.
// - Negative overdrive gives 0000 or 2000.
// - Loop is on after defaults are applied.
// - Missing or slow sample clock powers down.
// - Sample clock should be near 50% duty.
// - Sleep bit makes data high-impedance and holds the ready clock low.
// - Two microsecond reset pulse restores the control bits to defaults, data, flag and ready low.
module aso_sample_port import aso_pkg::*; #(
    parameter int RST_MIN_CYC = `ASO_RST_MIN_CYC,
    parameter int SLOW_CYC = `ASO_SLOW_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sampleClockPos,
    input wire logic [13:0] coreCode,
    input wire logic corePosOver,
    input wire logic coreNegOver,
    input wire logic [1:0] formatPolaritySelect,
    input wire logic outputEnable,
    input wire logic resetPin,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [13:0] resultBits,
    output logic resultOe,
    output logic overRangeFlag,
    output logic sampleReadyClock
);
    aso_main_state_type s_q;
    aso_main_state_type s_d;
    aso_ctrl_if ctrl ();
    logic [1:0] pinSync;
    logic rstPinSync;
    logic liveSync;

    // ======================================================================
    // Crossings
    aso_sync #(.W(2)) u_pin_sync (
        .clk(clk),
        .rst(sys_rst),
        .d({resetPin, ctrl.liveToggle}),
        .q(pinSync)
    );

    assign rstPinSync = pinSync[1];
    assign liveSync = pinSync[0];

    aso_sample_path u_path (
        .sampleClockPos(sampleClockPos),
        .ctrl(ctrl.link),
        .coreCode(coreCode),
        .corePosOver(corePosOver),
        .coreNegOver(coreNegOver),
        .formatPolaritySelect(formatPolaritySelect),
        .outputEnable(outputEnable),
        .resultBits(resultBits),
        .resultOe(resultOe),
        .overRangeFlag(overRangeFlag),
        .sampleReadyClock(sampleReadyClock)
    );

    // ======================================================================
    // Register read mux
    function automatic logic [31:0] reg_read(input logic [3:0] addr, input aso_main_state_type st);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (addr)
            `ASO_CTRL_OFS: begin
                v[`ASO_CTRL_DLLOFF_BIT] = st.dllOff;
                v[`ASO_CTRL_SLEEP_BIT] = st.sleep;
            end
            `ASO_STAT_OFS: begin
                v[`ASO_STAT_LOST_BIT] = st.clockLost;
                v[`ASO_STAT_DLLON_BIT] = !st.dllOff && !st.clockLost;
                v[`ASO_STAT_RST_BIT] = st.rstHold;
            end
            default: begin
                v = 32'h0000_0000;
            end
        endcase
        return v;
    endfunction

    // ======================================================================
    // Control logic
    always_comb begin
        s_d = s_q;

        // A stopped sample clock freezes the toggle; the watchdog needs no edge of it to notice.
        s_d.liveSeen = liveSync;
        if (liveSync != s_q.liveSeen) begin
            s_d.idleCnt = 16'h0000;
        end else if (s_q.idleCnt != 16'hFFFF) begin
            s_d.idleCnt = s_q.idleCnt + 16'h0001;
        end
        s_d.clockLost = (s_d.idleCnt >= 16'(SLOW_CYC));

        // Short glitches on the reset pin are filtered by the minimum width count.
        if (rstPinSync) begin
            if (s_q.rstCnt < 16'(RST_MIN_CYC)) begin
                s_d.rstCnt = s_q.rstCnt + 16'h0001;
            end
        end else begin
            s_d.rstCnt = 16'h0000;
        end
        s_d.rstHold = rstPinSync && (s_d.rstCnt >= 16'(RST_MIN_CYC));

        case (s_q.busSt)
            BUS_IDLE: begin
                s_d.waitReq = 1'b1;
                if (read || write) begin
                    s_d.busSt = BUS_ANSWER;
                    s_d.waitReq = 1'b0;
                    s_d.rdata = reg_read(address, s_q);
                end
            end
            BUS_ANSWER: begin
                if (write && address == `ASO_CTRL_OFS && byteenable[0]) begin
                    s_d.dllOff = writedata[`ASO_CTRL_DLLOFF_BIT];
                    s_d.sleep = writedata[`ASO_CTRL_SLEEP_BIT];
                end
                s_d.waitReq = 1'b1;
                s_d.busSt = BUS_IDLE;
            end
            default: begin
                s_d.waitReq = 1'b1;
                s_d.busSt = BUS_IDLE;
            end
        endcase

        if (s_d.rstHold) begin
            s_d.dllOff = `ASO_CTRL_DLLOFF_RST;
            s_d.sleep = `ASO_CTRL_SLEEP_RST;
        end
        s_d.powerDown = s_d.sleep || s_d.clockLost;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.busSt <= BUS_IDLE;
            s_q.waitReq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign readdata = s_q.rdata;
    assign waitrequest = s_q.waitReq;
    assign ctrl.powerDown = s_q.powerDown;
    assign ctrl.resetHold = s_q.rstHold;
    assign ctrl.sysRst = sys_rst;

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    bus_answer_a: assert property (s_q.busSt == BUS_IDLE && (read || write) |=> !waitrequest ##1 waitrequest)
        else $error("bus answer timing wrong");
    rst_width_a: assert property ($rose(s_q.rstHold)
                                  |-> $past(rstPinSync) && $past(s_q.rstCnt) == 16'(RST_MIN_CYC - 1))
        else $error("reset hold before minimum width");
    loop_default_a: assert property (s_q.rstHold |-> !s_q.dllOff && !s_q.sleep)
        else $error("loop not on after reset");
    lost_stable_a: assert property (s_q.clockLost |-> $past(liveSync) == $past(liveSync, 2))
        else $error("clock lost while toggle moved");
    lost_pdn_a: assert property ($rose(s_q.clockLost) |-> s_q.powerDown)
        else $error("lost clock did not power down");
    sleep_pdn_a: assert property (s_q.sleep |-> s_q.powerDown)
        else $error("sleep did not power down");
    wait_one_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    ctrl_write_a: assert property (write && !waitrequest && address == `ASO_CTRL_OFS && byteenable[0] ##1 !s_q.rstHold
                                   |-> s_q.dllOff == $past(writedata[`ASO_CTRL_DLLOFF_BIT])
                                       && s_q.sleep == $past(writedata[`ASO_CTRL_SLEEP_BIT]))
        else $error("control write did not land");
    stat_read_a: assert property (s_q.busSt == BUS_IDLE && read && address == `ASO_STAT_OFS
                                  |=> readdata[`ASO_STAT_LOST_BIT] == $past(s_q.clockLost)
                                      && readdata[`ASO_STAT_RST_BIT] == $past(s_q.rstHold))
        else $error("status read wrong");
    unmapped_zero_a: assert property (s_q.busSt == BUS_IDLE && read && address != `ASO_CTRL_OFS
                                      && address != `ASO_STAT_OFS |=> readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    pdn_cause_a: assert property (s_q.powerDown |-> s_q.sleep || s_q.clockLost)
        else $error("power-down without cause");
    hold_release_a: assert property (!rstPinSync |=> !s_q.rstHold)
        else $error("reset hold without reset pin");
    lost_clear_a: assert property (liveSync != s_q.liveSeen |=> !s_q.clockLost)
        else $error("clock lost while toggle moved");

    lost_c: cover property ($rose(s_q.clockLost));
    rstHold_c: cover property ($rose(s_q.rstHold));
    ctrlWrite_c: cover property (write && !waitrequest && address == `ASO_CTRL_OFS);
endmodule // aso_sample_port

//--- dv/aso_capture_model.sv
`timescale 1ns/100ps

// ============================================================
// Receiving logic that latches each word on the chosen ready edge.
module aso_capture_model (
    input wire logic sampleReadyClock,
    input wire logic [13:0] resultBits,
    input wire logic resultOe,
    input wire logic overRangeFlag,
    input wire logic fallEdge,
    output logic [13:0] capWord,
    output logic capFlag,
    output logic [15:0] capCount
);
    logic [13:0] busWord;
    logic busFlag;

    // A released bus floats, so the model sees no stale word.
    assign busWord = resultOe ? resultBits : 14'hZZZZ;
    assign busFlag = resultOe ? overRangeFlag : 1'bz;

    initial begin
        capWord = 14'h0000;
        capFlag = 1'b0;
        capCount = 16'h0000;
    end

    // Word and flag are taken at one edge so they belong to one sample.
    always @(posedge sampleReadyClock) begin
        if (!fallEdge) begin
            capWord <= busWord;
            capFlag <= busFlag;
            capCount <= capCount + 16'h0001;
        end
    end

    always @(negedge sampleReadyClock) begin
        if (fallEdge) begin
            capWord <= busWord;
            capFlag <= busFlag;
            capCount <= capCount + 16'h0001;
        end
    end
endmodule // aso_capture_model

//--- dv/aso_sample_port_tb.sv
`timescale 1ns/100ps

module aso_sample_port_tb;
    logic clk, sys_rst, sampleClockPos, sEn, corePosOver, coreNegOver, outputEnable, resetPin, read, write;
    logic [13:0] coreCode, resultBits, capWord, expW, base;
    logic [1:0] formatPolaritySelect;
    logic [3:0] address, byteenable;
    logic [31:0] writedata, readdata, rd;
    logic waitrequest, resultOe, overRangeFlag, sampleReadyClock, capFlag;
    logic [15:0] capCount, c0;
    int errors, nChecks;

    aso_sample_port #(.RST_MIN_CYC(8), .SLOW_CYC(16)) uut (.clk(clk), .sys_rst(sys_rst),
        .sampleClockPos(sampleClockPos), .coreCode(coreCode), .corePosOver(corePosOver),
        .coreNegOver(coreNegOver), .formatPolaritySelect(formatPolaritySelect), .outputEnable(outputEnable),
        .resetPin(resetPin), .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .resultBits(resultBits),
        .resultOe(resultOe), .overRangeFlag(overRangeFlag), .sampleReadyClock(sampleReadyClock));

    aso_capture_model capture (.sampleReadyClock(sampleReadyClock), .resultBits(resultBits),
        .resultOe(resultOe), .overRangeFlag(overRangeFlag), .fallEdge(formatPolaritySelect[1]),
        .capWord(capWord), .capFlag(capFlag), .capCount(capCount));

    // ============================================================
    // Clocks and watchdog
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // The sample clock stands still when disabled, to starve the loss detector.
    initial begin
        sampleClockPos = 1'b0;
        #1.7;
        forever #3 if (sEn) sampleClockPos = ~sampleClockPos;
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        end_sim;
    end

    // ============================================================
    // Tasks
    task automatic end_sim;
        $display("Checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkWord(input logic [13:0] got, input logic [13:0] exp);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Avalon access: request held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] d);
        int n;
        @(posedge clk);
        address <= a;
        writedata <= wd;
        write <= wr;
        read <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        d = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, n, 0);
        end
    endtask

    task automatic regRead(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000, rd);
        chkReg(rd, exp);
    endtask

    // ============================================================
    // Tests
    initial begin
        sys_rst = 1'b1;
        sEn = 1'b1;
        coreCode = 14'h0000;
        corePosOver = 1'b0;
        coreNegOver = 1'b0;
        formatPolaritySelect = 2'h0;
        outputEnable = 1'b1;
        resetPin = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        byteenable = 4'hF;
        errors = 0;
        nChecks = 0;
        idle(8);
        sys_rst <= 1'b0;
        idle(20);
        regRead(4'h0, 32'h00000000);
        regRead(4'h4, 32'h00000002);
        regRead(4'h8, 32'h00000000);
        // Every format and edge, with normal, both overdrives and an in-range limit code.
        for (int f = 0; f < 4; f++) begin
            for (int k = 0; k < 4; k++) begin
                c0 = capCount;
                formatPolaritySelect <= f[1:0];
                coreCode <= (k == 3) ? 14'h3FFF : 14'h1234;
                corePosOver <= (k == 1);
                coreNegOver <= (k == 2);
                base = (k == 1) ? 14'h3FFF : (k == 2) ? 14'h0000 : (k == 3) ? 14'h3FFF : 14'h1234;
                expW = f[0] ? (base ^ 14'h2000) : base;
                idle(30);
                chkWord(capWord, expW);
                chkReg({31'h0, capFlag}, {31'h0, (base == 14'h3FFF || base == 14'h0000)});
                chkReg({31'h0, capCount != c0}, 32'h00000001);
            end
        end
        outputEnable <= 1'b0;
        idle(20);
        chkReg({31'h0, resultOe}, 32'h00000000);
        outputEnable <= 1'b1;
        idle(20);
        chkReg({31'h0, resultOe}, 32'h00000001);
        bus(1'b1, 4'h0, 32'h00000002, rd);
        idle(20);
        chkReg({31'h0, resultOe}, 32'h00000000);
        bus(1'b1, 4'h0, 32'h00000001, rd);
        regRead(4'h4, 32'h00000000);
        idle(20);
        chkReg({31'h0, resultOe}, 32'h00000001);
        sEn = 1'b0;
        idle(100);
        regRead(4'h4, 32'h00000001);
        sEn = 1'b1;
        idle(50);
        regRead(4'h4, 32'h00000000);
        resetPin <= 1'b1;
        idle(30);
        regRead(4'h4, 32'h00000006);
        regRead(4'h0, 32'h00000000);
        chkWord(resultBits, 14'h0000);
        chkReg({31'h0, overRangeFlag}, 32'h00000000);
        resetPin <= 1'b0;
        idle(30);
        regRead(4'h4, 32'h00000002);
        // A control write without its low byte enabled must leave the loop and sleep bits alone.
        byteenable <= 4'hE;
        bus(1'b1, 4'h0, 32'h00000002, rd);
        byteenable <= 4'hF;
        regRead(4'h0, 32'h00000000);
        end_sim;
    end
endmodule // aso_sample_port_tb
